// >>> hw/gpio_sync_pixel_port.sv
`timescale 1ns/1ps
// Function
// - Copy decoder output, normal path untouched
// - Drive port clock at pixel rate
// - Range bit 0 set lifts the studio range limits
// - Line start low 64 clocks, bit 23
// - Field start low, bit 22, six lines
// - Odd field start two clocks after line
// - Even field start mid-line, line 263/313
// - Line active on bit 21, programmable
// - Pixel valid on bit 20, independent
// - Blue phase on bit 19, held invalid
// - Field parity bit 18, changes at active end
// - Frame active on bit 17, programmable
// - Blanking interval bit 16 ends at delay
// - Luma bits 15:8, chroma bits 7:0
// - Outputs change on port clock falling edge
// - Mode affects whole port, resets normal
module gpio_sync_pixel_port (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic pixelRateClock,
  input wire logic [7:0] vidLuma,
  input wire logic [7:0] vidChroma,
  input wire logic vidValid,
  input wire logic vidBlue,
  output logic [23:0] gpioOut,
  output logic [23:0] gpioOe,
  output logic portClock,
  output logic portClockOe
);
  typedef struct packed {
    logic clkSync1;
    logic clkSync2;
    logic clkSync3;
    logic [2:0] mode;
    logic rangeOff;
    logic std625;
    logic [9:0] horiz_delay_setting;
    logic [9:0] line_active_flag;
    logic [9:0] vert_delay_setting;
    logic [9:0] frame_active_flag;
    logic [10:0] linePixels;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [10:0] hCount;
    logic [9:0] lineNum;
    logic field;
    logic vsLow;
    logic [2:0] vsCnt;
    logic [10:0] vsStartH;
    logic [7:0] luma;
    logic [7:0] chroma;
    logic valid;
    logic blue;
    logic [23:0] pinOut;
  } state_type;

  state_type q;
  state_type next_q;
  logic rise;
  logic fall;
  logic outMode;
  logic [7:0] lumaLim;
  logic [7:0] chromaLim;
  logic [9:0] evenLine;
  logic [9:0] totalLines;
  logic evenHalf;
  logic [9:0] lif;
  logic [10:0] hEnd;
  logic [9:0] vEnd;
  logic [10:0] halfPlus;
  logic lineAct;
  logic frameAct;
  logic vbi;
  logic startOdd;
  logic startEven;
  logic [31:0] ctrlWord;
  logic [31:0] horizWord;
  logic [31:0] vertWord;
  logic [31:0] pixelsWord;
  logic [31:0] statusWord;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] upd,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = upd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------
  // Pixel clock edges and timing decode
  // ----------------------------------------
  assign rise = q.clkSync2 & ~q.clkSync3;
  assign fall = ~q.clkSync2 & q.clkSync3;
  assign outMode = q.mode == gpio_pixel_pkg::MODE_PIXEL_OUT;
  assign evenLine = q.std625 ? gpio_pixel_pkg::EVEN_LINE_625 : gpio_pixel_pkg::EVEN_LINE_525;
  assign totalLines = q.std625 ? gpio_pixel_pkg::LINES_625 : gpio_pixel_pkg::LINES_525;
  assign evenHalf = q.lineNum >= evenLine;
  assign lif = evenHalf ? q.lineNum - evenLine : q.lineNum - 10'h1;
  assign hEnd = {1'b0, q.horiz_delay_setting} + {1'b0, q.line_active_flag};
  assign vEnd = q.vert_delay_setting + q.frame_active_flag;
  assign halfPlus = {1'b0, q.linePixels[10:1]} + 11'h1;
  assign lineAct = q.hCount >= {1'b0, q.horiz_delay_setting} && q.hCount < hEnd;
  assign frameAct = lif >= q.vert_delay_setting && lif < vEnd;
  assign vbi = lif < q.vert_delay_setting;
  assign startOdd = q.lineNum == 10'h1 && q.hCount == gpio_pixel_pkg::ODD_FIELD_LAG;
  assign startEven = q.lineNum == evenLine && q.hCount == halfPlus;

  // Decoder samples are only read, so the normal video path sees no load
  range_clamp #(
    .LOW(gpio_pixel_pkg::LUMA_MIN),
    .HIGH(gpio_pixel_pkg::LUMA_MAX)
  ) lumaClamp (
    .enable(~q.rangeOff),
    .sample(vidLuma),
    .limited(lumaLim)
  );
  range_clamp #(
    .LOW(gpio_pixel_pkg::CHROMA_MIN),
    .HIGH(gpio_pixel_pkg::CHROMA_MAX)
  ) chromaClamp (
    .enable(~q.rangeOff),
    .sample(vidChroma),
    .limited(chromaLim)
  );

  // ----------------------------------------
  // Register images
  // ----------------------------------------
  always_comb begin
    ctrlWord = 32'h0;
    ctrlWord[gpio_pixel_pkg::RANGE_BIT] = q.rangeOff;
    ctrlWord[gpio_pixel_pkg::STD625_BIT] = q.std625;
    ctrlWord[gpio_pixel_pkg::MODE_LSB +: 3] = q.mode;
    horizWord = 32'h0;
    horizWord[9:0] = q.horiz_delay_setting;
    horizWord[gpio_pixel_pkg::ACTIVE_LSB +: 10] = q.line_active_flag;
    vertWord = 32'h0;
    vertWord[9:0] = q.vert_delay_setting;
    vertWord[gpio_pixel_pkg::ACTIVE_LSB +: 10] = q.frame_active_flag;
    pixelsWord = {21'h0, q.linePixels};
    statusWord = 32'h0;
    statusWord[9:0] = q.lineNum;
    statusWord[gpio_pixel_pkg::FIELD_BIT] = q.field;
    statusWord[gpio_pixel_pkg::FRAME_BIT] = frameAct;
    statusWord[gpio_pixel_pkg::VSLOW_BIT] = q.vsLow;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [31:0] w;
    w = 32'h0;
    next_q = q;
    next_q.clkSync1 = pixelRateClock;
    next_q.clkSync2 = q.clkSync1;
    next_q.clkSync3 = q.clkSync2;
    // Address and data may arrive in either order
    if (awvalid && awready) begin
      next_q.awHeld = 1'b1;
      next_q.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      next_q.wHeld = 1'b1;
      next_q.wData = wdata;
      next_q.wStrb = wstrb;
    end
    if (q.bvalid && bready) begin
      next_q.bvalid = 1'b0;
    end
    if (q.awHeld && q.wHeld) begin
      next_q.awHeld = 1'b0;
      next_q.wHeld = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = gpio_pixel_pkg::RESP_OKAY;
      if (q.awAddr == gpio_pixel_pkg::ADDR_CTRL) begin
        w = merge(ctrlWord, q.wData, q.wStrb);
        next_q.rangeOff = w[gpio_pixel_pkg::RANGE_BIT];
        next_q.std625 = w[gpio_pixel_pkg::STD625_BIT];
        next_q.mode = w[gpio_pixel_pkg::MODE_LSB +: 3];
      end else if (q.awAddr == gpio_pixel_pkg::ADDR_HORIZ) begin
        w = merge(horizWord, q.wData, q.wStrb);
        next_q.horiz_delay_setting = w[9:0];
        next_q.line_active_flag = w[gpio_pixel_pkg::ACTIVE_LSB +: 10];
      end else if (q.awAddr == gpio_pixel_pkg::ADDR_VERT) begin
        w = merge(vertWord, q.wData, q.wStrb);
        next_q.vert_delay_setting = w[9:0];
        next_q.frame_active_flag = w[gpio_pixel_pkg::ACTIVE_LSB +: 10];
      end else if (q.awAddr == gpio_pixel_pkg::ADDR_PIXELS) begin
        w = merge(pixelsWord, q.wData, q.wStrb);
        next_q.linePixels = w[10:0];
      end else if (q.awAddr != gpio_pixel_pkg::ADDR_STATUS) begin
        next_q.bresp = gpio_pixel_pkg::RESP_SLVERR;
      end
    end
    if (q.rvalid && rready) begin
      next_q.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_q.rvalid = 1'b1;
      next_q.rresp = gpio_pixel_pkg::RESP_OKAY;
      if (araddr == gpio_pixel_pkg::ADDR_CTRL) begin
        next_q.rdata = ctrlWord;
      end else if (araddr == gpio_pixel_pkg::ADDR_HORIZ) begin
        next_q.rdata = horizWord;
      end else if (araddr == gpio_pixel_pkg::ADDR_VERT) begin
        next_q.rdata = vertWord;
      end else if (araddr == gpio_pixel_pkg::ADDR_PIXELS) begin
        next_q.rdata = pixelsWord;
      end else if (araddr == gpio_pixel_pkg::ADDR_STATUS) begin
        next_q.rdata = statusWord;
      end else begin
        next_q.rdata = 32'h0;
        next_q.rresp = gpio_pixel_pkg::RESP_SLVERR;
      end
    end
    // Counters and samples advance on the pixel clock rising edge
    if (rise) begin
      // Wrap on >= so a shorter line length or line count takes hold at once
      if (q.hCount >= q.linePixels - 11'h1) begin
        next_q.hCount = 11'h0;
        next_q.lineNum = (q.lineNum >= totalLines) ? 10'h1 : q.lineNum + 10'h1;
      end else begin
        next_q.hCount = q.hCount + 11'h1;
      end
      next_q.luma = lumaLim;
      next_q.chroma = chromaLim;
      next_q.valid = vidValid;
      if (vidValid) begin
        next_q.blue = vidBlue;
      end
    end
    // Pins move half a pixel later, on the falling edge
    if (fall) begin
      if (startOdd || startEven) begin
        next_q.vsLow = 1'b1;
        next_q.vsCnt = 3'h0;
        next_q.vsStartH = q.hCount;
      end else if (q.vsLow && q.hCount == q.vsStartH) begin
        if (q.vsCnt == gpio_pixel_pkg::FIELD_START_LINES - 3'h1) begin
          next_q.vsLow = 1'b0;
        end else begin
          next_q.vsCnt = q.vsCnt + 3'h1;
        end
      end
      if (q.hCount == hEnd && lif == vEnd - 10'h1) begin
        next_q.field = evenHalf;
      end
      next_q.pinOut = {q.hCount >= gpio_pixel_pkg::LINE_START_CLOCKS,
                       ~next_q.vsLow, lineAct, q.valid, q.blue, next_q.field,
                       frameAct, vbi, q.luma, q.chroma};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.mode <= gpio_pixel_pkg::MODE_NORMAL;
      q.horiz_delay_setting <= gpio_pixel_pkg::HORIZ_DELAY_RST;
      q.line_active_flag <= gpio_pixel_pkg::HORIZ_ACTIVE_RST;
      q.vert_delay_setting <= gpio_pixel_pkg::VERT_DELAY_RST;
      q.frame_active_flag <= gpio_pixel_pkg::VERT_ACTIVE_RST;
      q.linePixels <= gpio_pixel_pkg::PIXELS_RST;
      // Line 0, one short of count zero: the first pixel opens line 1 with a real line-start edge
      q.hCount <= 11'h7ff;
      q.pinOut <= 24'hc00000;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign awready = ~q.awHeld & ~q.bvalid;
  assign wready = ~q.wHeld & ~q.bvalid;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = ~q.rvalid;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign gpioOut = q.pinOut;
  assign gpioOe = {24{outMode}};
  assign portClock = q.clkSync3;
  assign portClockOe = outMode;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_line_start_pos: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(gpioOut[23]) |-> q.hCount == 11'h0)
    else $error("line start fell away from count zero");
  a_odd_field_lag: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(gpioOut[22]) && q.lineNum == 10'h1 |-> q.hCount == 11'h2)
    else $error("odd field start not two clocks after line start");
  a_even_field_mid: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(gpioOut[22]) && q.lineNum != 10'h1 |-> q.lineNum == evenLine && q.hCount == halfPlus)
    else $error("even field start misplaced");
  a_line_active_start: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(gpioOut[21]) |-> q.hCount == {1'b0, q.horiz_delay_setting})
    else $error("line active rose off the delay");
  a_blue_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    rise && !vidValid |=> $stable(q.blue))
    else $error("blue phase changed on invalid pixel");
  a_field_parity_edge: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(q.field) |-> q.hCount == hEnd && !gpioOut[21])
    else $error("field parity changed away from active end");
  a_vbi_frame_split: assert property (@(posedge mclk) disable iff (!rst_n)
    gpioOut[17] |-> !gpioOut[16])
    else $error("blanking flag overlaps frame active");
  a_luma_range: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(gpioOut[15:8]) && !q.rangeOff && !$past(q.rangeOff, 24)
      |-> gpioOut[15:8] >= 8'h10 && gpioOut[15:8] <= 8'heb)
    else $error("luma outside studio range");
  a_change_on_fall: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(gpioOut) |-> $fell(portClock) && $past(fall))
    else $error("pins changed off the falling port clock");
  a_pins_released: assert property (@(posedge mclk) disable iff (!rst_n)
    q.mode != gpio_pixel_pkg::MODE_PIXEL_OUT |-> gpioOe == 24'h0 && !portClockOe)
    else $error("pins driven outside pixel output mode");
endmodule

// >>> hw/gpio_pixel_pkg.sv
package gpio_pixel_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_HORIZ = 8'h04;
  localparam logic [7:0] ADDR_VERT = 8'h08;
  localparam logic [7:0] ADDR_PIXELS = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam int RANGE_BIT = 0;
  localparam int STD625_BIT = 1;
  localparam int MODE_LSB = 10;
  localparam int ACTIVE_LSB = 16;
  localparam int FIELD_BIT = 16;
  localparam int FRAME_BIT = 17;
  localparam int VSLOW_BIT = 18;
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_PIXEL_OUT = 3'h2;
  localparam logic [2:0] MODE_PIXEL_IN = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [9:0] HORIZ_DELAY_RST = 10'h078;
  localparam logic [9:0] HORIZ_ACTIVE_RST = 10'h280;
  localparam logic [9:0] VERT_DELAY_RST = 10'h016;
  localparam logic [9:0] VERT_ACTIVE_RST = 10'h0f0;
  localparam logic [10:0] PIXELS_RST = 11'h38c;
  // ----------------------------------------
  // Video timing
  // ----------------------------------------
  localparam logic [9:0] LINES_525 = 10'h20d;
  localparam logic [9:0] LINES_625 = 10'h271;
  localparam logic [9:0] EVEN_LINE_525 = 10'h107;
  localparam logic [9:0] EVEN_LINE_625 = 10'h139;
  localparam logic [10:0] LINE_START_CLOCKS = 11'h040;
  localparam logic [10:0] ODD_FIELD_LAG = 11'h002;
  localparam logic [2:0] FIELD_START_LINES = 3'h6;
  localparam logic [7:0] LUMA_MIN = 8'h10;
  localparam logic [7:0] LUMA_MAX = 8'heb;
  localparam logic [7:0] CHROMA_MIN = 8'h10;
  localparam logic [7:0] CHROMA_MAX = 8'hf0;
endpackage

// >>> hw/range_clamp.sv
`timescale 1ns/1ps
module range_clamp #(
  parameter logic [7:0] LOW = 8'h10,
  parameter logic [7:0] HIGH = 8'heb
) (
  input wire logic enable,
  input wire logic [7:0] sample,
  output logic [7:0] limited
);
  // ----------------------------------------
  // Studio range limiter
  // ----------------------------------------
  always_comb begin
    limited = sample;
    if (enable && sample < LOW) begin
      limited = LOW;
    end else if (enable && sample > HIGH) begin
      limited = HIGH;
    end
  end
endmodule

// >>> tb/pixel_capture_model.sv
`timescale 1ns/1ps
// ----
// Receiver latching the port on rising port_clock
// ----
module pixel_capture_model (
  input wire logic mclk,
  input wire logic [23:0] gpioOut,
  input wire logic portClock,
  input wire logic portClockOe,
  output logic [23:0] sample,
  output int lineLowRun,
  output int fieldLag,
  output int activeStart,
  output int activeRun,
  output int clockPeriod,
  output int edgeFaults
);
  logic prevClk = 1'b0;
  logic [23:0] prevOut = 24'h000000;
  int hCount = 0;
  int lowCnt = 0;
  int actCnt = 0;
  int period = 0;
  logic [23:0] held = 24'hc00000;
  assign sample = held;
  always @(posedge mclk) begin
    if (portClockOe) begin
      period++;
      // Any change away from a port_clock fall would eat the receiver's margin
      if (gpioOut !== prevOut && !(prevClk && !portClock)) edgeFaults++;
      if (!prevClk && portClock) begin
        clockPeriod = period;
        period = 0;
        hCount = (held[23] && !gpioOut[23]) ? 0 : hCount + 1;
        if (held[22] && !gpioOut[22]) fieldLag = hCount;
        if (gpioOut[23] && lowCnt > 0) lineLowRun = lowCnt;
        lowCnt = gpioOut[23] ? 0 : lowCnt + 1;
        if (gpioOut[21] && actCnt == 0) activeStart = hCount;
        if (!gpioOut[21] && actCnt > 0) activeRun = actCnt;
        actCnt = gpioOut[21] ? actCnt + 1 : 0;
        held = gpioOut;
      end
    end
    prevClk = portClock;
    prevOut = gpioOut;
  end
endmodule

// >>> tb/gpio_sync_pixel_port_bench.sv
`timescale 1ns/1ps
module gpio_sync_pixel_port_bench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic pixelRateClock = 1'b0;
  logic pixRun = 1'b0;
  logic [7:0] vidLuma = 8'h00;
  logic [7:0] vidChroma = 8'h00;
  logic vidValid = 1'b0;
  logic vidBlue = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, portClock, portClockOe;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [23:0] gpioOut, gpioOe, sample;
  int lineLowRun, fieldLag, activeStart, activeRun, clockPeriod, edgeFaults;
  int failures = 0;
  int comparisons = 0;
  initial forever #2 mclk = ~mclk;
  // Link clock stands still low while no video is offered
  initial begin
    #5;
    forever #24 pixelRateClock = pixRun & ~pixelRateClock;
  end
  gpio_sync_pixel_port dut (.mclk(mclk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pixelRateClock(pixelRateClock), .vidLuma(vidLuma), .vidChroma(vidChroma),
    .vidValid(vidValid), .vidBlue(vidBlue), .gpioOut(gpioOut), .gpioOe(gpioOe),
    .portClock(portClock), .portClockOe(portClockOe));
  pixel_capture_model receiver (.mclk(mclk), .gpioOut(gpioOut), .portClock(portClock),
    .portClockOe(portClockOe), .sample(sample), .lineLowRun(lineLowRun), .fieldLag(fieldLag),
    .activeStart(activeStart), .activeRun(activeRun), .clockPeriod(clockPeriod),
    .edgeFaults(edgeFaults));
  // ----
  // Shared tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // Handshakes are judged before the edge, released just after it
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    logic aw;
    logic w;
    logic b;
    logic [1:0] r;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge mclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge mclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (!b);
    bready <= 1'b0;
    check({30'h0, r}, {30'h0, resp}, "write response");
    // Let an edge pass so a following call never re-raises a strobe in the same step
    @(posedge mclk);
  endtask
  task automatic read_reg(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] resp);
    logic ar;
    logic v;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge mclk);
      ar = arvalid && arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (ar) arvalid <= 1'b0;
    end while (!v);
    rready <= 1'b0;
    check(d, exp, "read data");
    check({30'h0, r}, {30'h0, resp}, "read response");
    @(posedge mclk);
  endtask
  task automatic set_vid(input logic [7:0] y, input logic [7:0] c, input logic v, input logic cb);
    @(negedge pixelRateClock);
    @(posedge mclk);
    vidLuma <= y;
    vidChroma <= c;
    vidValid <= v;
    vidBlue <= cb;
    repeat (60) @(posedge mclk);
  endtask
  task automatic pins_off;
    @(negedge mclk);
    check({8'h0, gpioOe}, 32'h0, "port enables");
    check({31'h0, portClockOe}, 32'h0, "clock enable");
    @(posedge mclk);
  endtask
  task automatic close_out;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    close_out();
  end
  // ----
  // Tests
  // ----
  initial begin
    repeat (18) @(posedge mclk);
    @(negedge mclk);
    check({8'h0, gpioOut}, 32'h00c00000, "reset pins");
    pins_off();
    rst_n <= 1'b1;
    @(posedge mclk);
    read_reg(gpio_pixel_pkg::ADDR_CTRL, 32'h0, gpio_pixel_pkg::RESP_OKAY);
    read_reg(gpio_pixel_pkg::ADDR_HORIZ, 32'h02800078, gpio_pixel_pkg::RESP_OKAY);
    read_reg(gpio_pixel_pkg::ADDR_VERT, 32'h00f00016, gpio_pixel_pkg::RESP_OKAY);
    read_reg(gpio_pixel_pkg::ADDR_PIXELS, 32'h0000038c, gpio_pixel_pkg::RESP_OKAY);
    read_reg(8'h14, 32'h0, gpio_pixel_pkg::RESP_SLVERR);
    write_reg(8'h14, 32'hffffffff, gpio_pixel_pkg::RESP_SLVERR);
    $display("test registers done");
    // Short lines keep two whole lines inside the run
    write_reg(gpio_pixel_pkg::ADDR_PIXELS, 32'h00000064, gpio_pixel_pkg::RESP_OKAY);
    write_reg(gpio_pixel_pkg::ADDR_HORIZ, 32'h0014000a, gpio_pixel_pkg::RESP_OKAY);
    write_reg(gpio_pixel_pkg::ADDR_CTRL, 32'h00000800, gpio_pixel_pkg::RESP_OKAY);
    @(negedge mclk);
    check({8'h0, gpioOe}, 32'h00ffffff, "port enables");
    check({31'h0, portClockOe}, 32'h1, "clock enable");
    @(posedge mclk);
    vidLuma <= 8'hff;
    vidChroma <= 8'h00;
    vidValid <= 1'b1;
    vidBlue <= 1'b1;
    pixRun <= 1'b1;
    repeat (2600) @(posedge mclk);
    check(clockPeriod, 32'd12, "port clock period");
    check(lineLowRun, 32'd64, "line start length");
    check(fieldLag, 32'd2, "odd field lag");
    check(activeStart, 32'd10, "active start");
    check(activeRun, 32'd20, "active length");
    check({16'h0, sample[15:0]}, 32'h0000eb10, "studio range");
    check({28'h0, sample[22], sample[18:16]}, 32'h1, "early odd field flags");
    $display("test timing done");
    set_vid(8'h80, 8'h80, 1'b0, 1'b0);
    check({31'h0, sample[20]}, 32'h0, "pixel valid low");
    check({31'h0, sample[19]}, 32'h1, "blue phase held");
    write_reg(gpio_pixel_pkg::ADDR_CTRL, 32'h00000801, gpio_pixel_pkg::RESP_OKAY);
    set_vid(8'hff, 8'h00, 1'b1, 1'b0);
    check({16'h0, sample[15:0]}, 32'h0000ff00, "full range lanes");
    check({31'h0, sample[20]}, 32'h1, "pixel valid high");
    check({31'h0, sample[19]}, 32'h0, "blue phase follows");
    check(edgeFaults, 32'd0, "changes off falling edge");
    $display("test pixels done");
    write_reg(gpio_pixel_pkg::ADDR_CTRL, 32'h00001000, gpio_pixel_pkg::RESP_OKAY);
    // Input mode releases all 24 port pins and the port clock to the far source
    pins_off();
    write_reg(gpio_pixel_pkg::ADDR_CTRL, 32'h00000000, gpio_pixel_pkg::RESP_OKAY);
    pins_off();
    pixRun <= 1'b0;
    $display("test modes done");
    close_out();
  end
endmodule
